// ### ugp_pkg.sv
/*
 * ugp_pkg: constants, types and helpers shared by both ends of the
 * uplink gmii/rgmii port. Assumes one 40 MHz core clock on each end.
 */
`default_nettype none
package ugp_pkg;
   localparam int CORE_PERIOD_NS = 25;
   // link clock scaled down so a 40 MHz sampler can follow it
   localparam int LINK_PERIOD_NS = 200;
   localparam int SLOW_FACTOR    = 5;
   localparam int CNT_W          = 5;
   localparam int HALF_GIG_CYC   = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
   localparam int HALF_SLOW_CYC  = HALF_GIG_CYC * SLOW_FACTOR;
   localparam logic [CNT_W-1:0] HALF_GIG  = CNT_W'(HALF_GIG_CYC);
   localparam logic [CNT_W-1:0] HALF_SLOW = CNT_W'(HALF_SLOW_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
   localparam int EG_DLY_CYC     = HALF_GIG_CYC / 2;
   localparam int STRAP_W        = 2;
   localparam logic [STRAP_W-1:0] STRAP_CYC = 2'h3;

   localparam int ADDR_W = 8;
   localparam int REG_W  = 8;
   localparam int BYTE_W = 8;
   localparam int NIB_W  = 4;
   localparam int IFSEL_W = 2;
   localparam logic [ADDR_W-1:0] CFG_OFFSET = 8'h56;
   localparam logic [ADDR_W-1:0] DRV_OFFSET = 8'hA4;
   localparam logic [REG_W-1:0]  CFG_RESET  = 8'h4B;
   localparam logic [REG_W-1:0]  DRV_RESET  = 8'h00;
   localparam logic [REG_W-1:0]  REG_ZERO   = 8'h00;
   localparam int CFG_SPARE_HI_BIT = 7;
   localparam int CFG_SPEED_BIT    = 6;
   localparam int CFG_HALF_BIT     = 5;
   localparam int CFG_IN_DLY_BIT   = 4;
   localparam int CFG_EG_DLY_BIT   = 3;
   localparam int CFG_SPARE_LO_BIT = 2;
   localparam int CFG_IFSEL_LSB    = 0;
   localparam logic [IFSEL_W-1:0] IFSEL_RGMII = 2'h3;
   localparam logic [NIB_W-1:0]   NIB_PAD     = 4'h0;

   typedef enum logic [1:0] {
      PH_LOW  = 2'b01,
      PH_HIGH = 2'b10
   } ugp_phase_type;

   function automatic logic [NIB_W-1:0] ugp_nib(input logic [BYTE_W-1:0] b,
                                                input logic hi);
      ugp_nib = hi ? b[NIB_W +: NIB_W] : b[0 +: NIB_W];
   endfunction

   function automatic logic [BYTE_W-1:0] ugp_pad(input logic [NIB_W-1:0] n);
      ugp_pad = {NIB_PAD, n};
   endfunction
endpackage
`default_nettype wire

// ### ugp_link_if.sv
/*
 * ugp_link_if: the uplink pins between the switch port and its partner.
 * In reduced mode tx_enable carries the tx control line, rx_valid the
 * rx control line, and data bits [3:0] carry the nibbles.
 */
`timescale 1ns/10ps
`default_nettype none
interface ugp_link_if;
   logic       uplink_tx_enable_in;
   logic       uplink_tx_error_in;
   logic [7:0] uplink_tx_data_in;
   logic       uplink_tx_clock_in;
   logic       uplink_rx_valid_out;
   logic       uplink_rx_error_out;
   logic [7:0] uplink_rx_data_out;
   logic       uplink_rx_clock_out;
   logic       col_dev_o;
   logic       col_dev_oe;
   logic       col_host_o;
   logic       col_host_oe;
   logic       crs_dev_o;
   logic       crs_dev_oe;
   logic       crs_host_o;
   logic       crs_host_oe;
   wire        uplink_collision;
   wire        uplink_carrier_sense;

   // undriven media status pins read low
   assign uplink_collision = col_dev_oe ? col_dev_o : (col_host_oe & col_host_o);
   assign uplink_carrier_sense = crs_dev_oe ? crs_dev_o : (crs_host_oe & crs_host_o);

   modport device (
      input  uplink_tx_enable_in, uplink_tx_error_in, uplink_tx_data_in,
      input  uplink_tx_clock_in, uplink_collision, uplink_carrier_sense,
      output uplink_rx_valid_out, uplink_rx_error_out, uplink_rx_data_out,
      output uplink_rx_clock_out, col_dev_o, col_dev_oe, crs_dev_o, crs_dev_oe
   );
   modport host (
      output uplink_tx_enable_in, uplink_tx_error_in, uplink_tx_data_in,
      output uplink_tx_clock_in, col_host_o, col_host_oe, crs_host_o, crs_host_oe,
      input  uplink_rx_valid_out, uplink_rx_error_out, uplink_rx_data_out,
      input  uplink_rx_clock_out, uplink_collision, uplink_carrier_sense
   );
endinterface
`default_nettype wire

// ### ugp_host_end.sv
/*
 * ugp_host_end: the link partner (external mac or phy). It makes the
 * tx link clock from its core clock and samples the port's rx pins.
 * Assumes plain same-domain configuration inputs from its own logic.
 */
`timescale 1ns/10ps
`default_nettype none
module ugp_host_end (
   input  wire logic                        core_clk_i,
   input  wire logic                        rstn_i,
   ugp_link_if.host                         link,
   input  wire logic                        phy_role_i,
   input  wire logic                        rgmii_i,
   input  wire logic                        gig_i,
   input  wire logic                        half_i,
   input  wire logic                        tx_delay_i,
   input  wire logic                        rx_delay_i,
   input  wire logic                        tx_valid_i,
   input  wire logic                        tx_error_i,
   input  wire logic [ugp_pkg::BYTE_W-1:0]  tx_data_i,
   output logic                             tx_ready_o,
   output logic                             rx_valid_o,
   output logic                             rx_error_o,
   output logic [ugp_pkg::BYTE_W-1:0]       rx_data_o,
   output logic                             rx_frame_o,
   output logic                             collision_o,
   output logic                             carrier_o
);
   import ugp_pkg::*;

   logic [CNT_W-1:0] cnt;
   logic clk_q, hval, herr, p_en, p_er, p_clk, c1, have, eacc, re_d, fe_d;
   logic clk1, clk2, clk3;
   logic [EG_DLY_CYC-1:0] pipe;
   logic [BYTE_W-1:0] hold, p_d;
   logic [NIB_W-1:0] lo;
   logic [BYTE_W+3:0] sy1, sy2, sy3;
   ugp_phase_type ph, next_ph;
   logic s_col, s_crs, s_dv, s_er;
   logic [BYTE_W-1:0] s_d;

   wire hd      = ~gig_i & half_i;
   wire tick    = (cnt == '0);
   wire fall    = tick & clk_q;
   wire rise    = tick & ~clk_q;
   wire next_clk = clk_q ^ tick;
   wire first   = ~rgmii_i | gig_i | (ph == PH_LOW);
   wire [CNT_W-1:0] half = gig_i ? HALF_GIG : HALF_SLOW;
   wire re = clk2 & ~clk3;
   wire fe = ~clk2 & clk3;
   wire rc = rx_delay_i ? re_d : re;
   wire fc = rx_delay_i ? fe_d : fe;
   wire drive_mii = phy_role_i & ~rgmii_i;

   assign {s_col, s_crs, s_dv, s_er, s_d} = sy3;
   assign link.uplink_tx_enable_in = p_en;
   assign link.uplink_tx_error_in  = p_er;
   assign link.uplink_tx_data_in   = p_d;
   assign link.uplink_tx_clock_in  = p_clk;

   always_comb begin
      next_ph = ph;
      case (ph)
         PH_LOW:  if (rise & rgmii_i & ~gig_i & tx_valid_i) next_ph = PH_HIGH;
         PH_HIGH: if (rise) next_ph = PH_LOW;
         default: next_ph = PH_LOW;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= '0; clk_q <= 1'b0; pipe <= '0; p_clk <= 1'b0; ph <= PH_LOW;
         tx_ready_o <= 1'b0;
      end else begin
         cnt <= tick ? half - CNT_ONE : cnt - CNT_ONE;
         clk_q <= next_clk;
         pipe <= {pipe[EG_DLY_CYC-2:0], next_clk};
         p_clk <= tx_delay_i ? pipe[EG_DLY_CYC-1] : next_clk;
         ph <= next_ph;
         tx_ready_o <= rise & first & tx_valid_i;
      end
   end

   // transmit launch: byte or low nibble on the rising tick, second half on the falling (gigabit) or next rising tick (10/100)
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold <= '0; hval <= 1'b0; herr <= 1'b0; p_en <= 1'b0; p_er <= 1'b0; p_d <= '0;
      end else if (rise) begin
         if (first) begin
            hold <= tx_data_i; hval <= tx_valid_i; herr <= tx_valid_i & tx_error_i;
            p_en <= tx_valid_i;
            p_er <= ~rgmii_i & tx_valid_i & tx_error_i;
            p_d  <= rgmii_i ? ugp_pad(ugp_nib(tx_data_i, 1'b0)) : tx_data_i;
         end else begin
            p_d  <= ugp_pad(ugp_nib(hold, 1'b1));
            p_en <= hval;
         end
      end else if (fall & rgmii_i) begin
         p_en <= hval ^ herr;
         if (gig_i) p_d <= ugp_pad(ugp_nib(hold, 1'b1));
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clk1 <= 1'b0; clk2 <= 1'b0; clk3 <= 1'b0; sy1 <= '0; sy2 <= '0; sy3 <= '0;
         re_d <= 1'b0; fe_d <= 1'b0;
      end else begin
         clk1 <= link.uplink_rx_clock_out; clk2 <= clk1; clk3 <= clk2;
         sy1 <= {link.uplink_collision, link.uplink_carrier_sense,
                 link.uplink_rx_valid_out, link.uplink_rx_error_out,
                 link.uplink_rx_data_out};
         sy2 <= sy1; sy3 <= sy2;
         re_d <= re; fe_d <= fe;
      end
   end

   // receive capture, mirror of the port's ingress side
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_valid_o <= 1'b0; rx_error_o <= 1'b0; rx_data_o <= '0; rx_frame_o <= 1'b0;
         lo <= '0; c1 <= 1'b0; have <= 1'b0; eacc <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         rx_frame_o <= c1;
         if (rc) begin
            c1 <= s_dv;
            if (!rgmii_i) begin
               rx_valid_o <= s_dv; rx_data_o <= s_d; rx_error_o <= s_er;
            end else if (gig_i) begin
               lo <= ugp_nib(s_d, 1'b0);
            end else if (!s_dv) begin
               have <= 1'b0; eacc <= 1'b0;
            end else if (have) begin
               rx_valid_o <= 1'b1; rx_error_o <= eacc; have <= 1'b0; eacc <= 1'b0;
               rx_data_o <= {ugp_nib(s_d, 1'b0), lo};
            end else begin
               lo <= ugp_nib(s_d, 1'b0); have <= 1'b1;
            end
         end else if (fc & rgmii_i) begin
            if (gig_i & c1) begin
               rx_valid_o <= 1'b1; rx_error_o <= c1 ^ s_dv;
               rx_data_o <= {ugp_nib(s_d, 1'b0), lo};
            end else if (!gig_i & (c1 ^ s_dv) & have) begin
               eacc <= 1'b1;
            end
         end
      end
   end

   // acting as phy in gmii mode the partner owns the media status pins
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link.col_host_o <= 1'b0; link.crs_host_o <= 1'b0;
         link.col_host_oe <= 1'b0; link.crs_host_oe <= 1'b0;
         collision_o <= 1'b0; carrier_o <= 1'b0;
      end else begin
         link.col_host_oe <= drive_mii;
         link.crs_host_oe <= drive_mii;
         link.col_host_o <= hd & p_en & c1;
         link.crs_host_o <= p_en | c1;
         collision_o <= drive_mii ? hd & p_en & c1 : s_col;
         carrier_o   <= drive_mii ? p_en | c1 : s_crs;
      end
   end
endmodule
`default_nettype wire

// ### ugp_device_end.sv
/*
 * ugp_device_end: the switch's uplink port, gmii (8 bit) or rgmii
 * (4 bit, both edges). Drives the rx clock from a core-clock divider and
 * samples the partner's tx clock. Assumes one 40 MHz core clock.
 */
`timescale 1ns/10ps
`default_nettype none
// Function
// - role strap at reset picks mac or phy
// - phy role: tx pins in, status out in gmii
// - mac role: rx pins out, status in
// - gmii moves eight bits per clock
// - gigabit rate is full duplex only
// - half duplex raises collision when transmit and receive overlap; the code does so in gmii only, never in rgmii
// - reduced mode: control, nibble, clock each way
// - rgmii with adjustable ingress/egress clock delay
// - bit 4 delays ingress clock, reset 0
// - bit 3 delays egress clock, reset 1
// - partner sets complementary clock delays
// - select field 11 picks rgmii, default
// - bit 6 picks gigabit, else 10/100
// - gigabit gmii moves one byte per clock
// - rgmii gigabit latches nibbles on both edges
module ugp_device_end (
   input  wire logic                        core_clk_i,
   input  wire logic                        rstn_i,
   ugp_link_if.device                       link,
   input  wire logic                        role_select_strap_i,
   input  wire logic [ugp_pkg::IFSEL_W-1:0] interface_select_strap_i,
   input  wire logic                        speed_select_strap_i,
   input  wire logic [ugp_pkg::ADDR_W-1:0]  reg_addr_i,
   input  wire logic                        reg_write_i,
   input  wire logic [ugp_pkg::REG_W-1:0]   reg_wdata_i,
   output logic [ugp_pkg::REG_W-1:0]        reg_rdata_o,
   output logic                             phy_role_o,
   input  wire logic                        tx_valid_i,
   input  wire logic                        tx_error_i,
   input  wire logic [ugp_pkg::BYTE_W-1:0]  tx_data_i,
   output logic                             tx_ready_o,
   output logic                             rx_valid_o,
   output logic                             rx_error_o,
   output logic [ugp_pkg::BYTE_W-1:0]       rx_data_o,
   output logic                             rx_frame_o,
   output logic                             collision_o,
   output logic                             carrier_o
);
   import ugp_pkg::*;

   logic [CNT_W-1:0] cnt;
   logic clk_q, hval, herr, p_dv, p_er, p_clk, c1, have, eacc, re_d, fe_d;
   logic clk1, clk2, clk3;
   logic [EG_DLY_CYC-1:0] pipe;
   logic [BYTE_W-1:0] hold, p_d, drv_reg;
   logic [NIB_W-1:0] lo;
   logic [BYTE_W+7:0] sy1, sy2, sy3;
   ugp_phase_type ph, next_ph;
   logic s_role, s_speed, s_col, s_crs, s_en, s_er;
   logic [IFSEL_W-1:0] s_ifsel, ifsel;
   logic [BYTE_W-1:0] s_d;
   logic [STRAP_W-1:0] strap_cnt;
   logic strap_done, spare_hi, speed, half_req, in_dly, eg_dly, spare_lo;

   wire rg       = (ifsel == IFSEL_RGMII);
   wire gig      = speed;
   wire hd       = ~gig & half_req;
   wire tick     = (cnt == '0);
   wire fall     = tick & clk_q;
   wire rise     = tick & ~clk_q;
   wire next_clk = clk_q ^ tick;
   wire first    = ~rg | gig | (ph == PH_LOW);
   wire [CNT_W-1:0] half = gig ? HALF_GIG : HALF_SLOW;
   wire re = clk2 & ~clk3;
   wire fe = ~clk2 & clk3;
   wire rc = in_dly ? re_d : re;
   wire fc = in_dly ? fe_d : fe;
   wire drive_mii = phy_role_o & ~rg;
   wire cfg_hit = reg_write_i & (reg_addr_i == CFG_OFFSET);
   wire drv_hit = reg_write_i & (reg_addr_i == DRV_OFFSET);
   wire [REG_W-1:0] cfg_val = {spare_hi, speed, half_req, in_dly, eg_dly, spare_lo, ifsel};
   wire [REG_W-1:0] rd_val = (reg_addr_i == CFG_OFFSET) ? cfg_val :
                             (reg_addr_i == DRV_OFFSET) ? drv_reg : REG_ZERO;

   assign {s_role, s_ifsel, s_speed, s_col, s_crs, s_en, s_er, s_d} = sy3;
   assign link.uplink_rx_valid_out = p_dv;
   assign link.uplink_rx_error_out = p_er;
   assign link.uplink_rx_data_out  = p_d;
   assign link.uplink_rx_clock_out = p_clk;

   always_comb begin
      next_ph = ph;
      case (ph)
         PH_LOW:  if (rise & rg & ~gig & tx_valid_i) next_ph = PH_HIGH;
         PH_HIGH: if (rise) next_ph = PH_LOW;
         default: next_ph = PH_LOW;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         clk1 <= 1'b0; clk2 <= 1'b0; clk3 <= 1'b0; sy1 <= '0; sy2 <= '0; sy3 <= '0;
         re_d <= 1'b0; fe_d <= 1'b0;
      end else begin
         clk1 <= link.uplink_tx_clock_in; clk2 <= clk1; clk3 <= clk2;
         sy1 <= {role_select_strap_i, interface_select_strap_i, speed_select_strap_i,
                 link.uplink_collision, link.uplink_carrier_sense,
                 link.uplink_tx_enable_in, link.uplink_tx_error_in, link.uplink_tx_data_in};
         sy2 <= sy1; sy3 <= sy2;
         re_d <= re; fe_d <= fe;
      end
   end

   // straps are caught once the synchroniser has settled after reset
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         strap_cnt <= '0; strap_done <= 1'b0; phy_role_o <= 1'b0;
         {spare_hi, speed, half_req, in_dly, eg_dly, spare_lo, ifsel} <= CFG_RESET;
         drv_reg <= DRV_RESET; reg_rdata_o <= REG_ZERO;
      end else begin
         reg_rdata_o <= rd_val;
         if (!strap_done) begin
            strap_cnt <= strap_cnt + 1'b1;
            if (strap_cnt == STRAP_CYC) begin
               strap_done <= 1'b1;
               phy_role_o <= s_role;
               ifsel <= s_ifsel;
               speed <= s_speed;
            end
         end else if (cfg_hit) begin
            spare_hi <= reg_wdata_i[CFG_SPARE_HI_BIT];
            speed    <= reg_wdata_i[CFG_SPEED_BIT];
            half_req <= reg_wdata_i[CFG_HALF_BIT];
            in_dly   <= reg_wdata_i[CFG_IN_DLY_BIT];
            eg_dly   <= reg_wdata_i[CFG_EG_DLY_BIT];
            spare_lo <= reg_wdata_i[CFG_SPARE_LO_BIT];
            ifsel    <= reg_wdata_i[CFG_IFSEL_LSB +: IFSEL_W];
         end else if (drv_hit) begin
            drv_reg <= reg_wdata_i;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= '0; clk_q <= 1'b0; pipe <= '0; p_clk <= 1'b0; ph <= PH_LOW;
         tx_ready_o <= 1'b0;
      end else begin
         cnt <= tick ? half - CNT_ONE : cnt - CNT_ONE;
         clk_q <= next_clk;
         pipe <= {pipe[EG_DLY_CYC-2:0], next_clk};
         p_clk <= eg_dly ? pipe[EG_DLY_CYC-1] : next_clk;
         ph <= next_ph;
         tx_ready_o <= rise & first & tx_valid_i;
      end
   end

   // egress launch: byte or low nibble on the rising tick, rgmii second half on the falling (gigabit) or next rising tick (10/100);
   // data leaves with the clock edge that carries it, so one delay on either end centres it
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold <= '0; hval <= 1'b0; herr <= 1'b0; p_dv <= 1'b0; p_er <= 1'b0; p_d <= '0;
      end else if (rise) begin
         if (first) begin
            hold <= tx_data_i; hval <= tx_valid_i; herr <= tx_valid_i & tx_error_i;
            p_dv <= tx_valid_i;
            p_er <= ~rg & tx_valid_i & tx_error_i;
            p_d  <= rg ? ugp_pad(ugp_nib(tx_data_i, 1'b0)) : tx_data_i;
         end else begin
            p_d  <= ugp_pad(ugp_nib(hold, 1'b1));
            p_dv <= hval;
         end
      end else if (fall & rg) begin
         p_dv <= hval ^ herr;
         if (gig) p_d <= ugp_pad(ugp_nib(hold, 1'b1));
      end
   end

   // ingress capture; in 10/100 reduced mode an odd trailing nibble is dropped
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_valid_o <= 1'b0; rx_error_o <= 1'b0; rx_data_o <= '0; rx_frame_o <= 1'b0;
         lo <= '0; c1 <= 1'b0; have <= 1'b0; eacc <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         rx_frame_o <= c1;
         if (rc) begin
            c1 <= s_en;
            if (!rg) begin
               rx_valid_o <= s_en; rx_data_o <= s_d; rx_error_o <= s_er;
            end else if (gig) begin
               lo <= ugp_nib(s_d, 1'b0);
            end else if (!s_en) begin
               have <= 1'b0; eacc <= 1'b0;
            end else if (have) begin
               rx_valid_o <= 1'b1; rx_error_o <= eacc; have <= 1'b0; eacc <= 1'b0;
               rx_data_o <= {ugp_nib(s_d, 1'b0), lo};
            end else begin
               lo <= ugp_nib(s_d, 1'b0); have <= 1'b1;
            end
         end else if (fc & rg) begin
            if (gig & c1) begin
               rx_valid_o <= 1'b1; rx_error_o <= c1 ^ s_en;
               rx_data_o <= {ugp_nib(s_d, 1'b0), lo};
            end else if (!gig & (c1 ^ s_en) & have) begin
               eacc <= 1'b1;
            end
         end
      end
   end

   // rgmii has no status pins, so they are released in that mode
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         link.col_dev_o <= 1'b0; link.crs_dev_o <= 1'b0;
         link.col_dev_oe <= 1'b0; link.crs_dev_oe <= 1'b0;
         collision_o <= 1'b0; carrier_o <= 1'b0;
      end else begin
         link.col_dev_oe <= drive_mii;
         link.crs_dev_oe <= drive_mii;
         link.col_dev_o <= hd & s_en & p_dv;
         link.crs_dev_o <= s_en | p_dv;
         collision_o <= drive_mii ? hd & s_en & p_dv : s_col;
         carrier_o   <= drive_mii ? s_en | p_dv : s_crs;
      end
   end
endmodule
`default_nettype wire

// ### ugp_link_checker.sv
/*
 * ugp_link_checker: wire-level assertions on the uplink pins.
 * Assumes both ends share core_clk_i and rstn_i, and the link clocks
 * are divided down from that clock.
 */
`timescale 1ns/10ps
`default_nettype none
module ugp_link_checker (
   input  wire logic       core_clk_i,
   input  wire logic       rstn_i,
   input  wire logic       uplink_tx_enable_in,
   input  wire logic       uplink_tx_error_in,
   input  wire logic [7:0] uplink_tx_data_in,
   input  wire logic       uplink_tx_clock_in,
   input  wire logic       uplink_rx_valid_out,
   input  wire logic       uplink_rx_error_out,
   input  wire logic [7:0] uplink_rx_data_out,
   input  wire logic       uplink_rx_clock_out,
   input  wire logic       uplink_collision,
   input  wire logic       uplink_carrier_sense
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   // launch may lead the clock pin by the two-cycle egress delay
   sequence s_rx_edge_soon;
      ##[0:2] $changed(uplink_rx_clock_out);
   endsequence
   sequence s_tx_edge_soon;
      ##[0:2] $changed(uplink_tx_clock_in);
   endsequence
   a_rx_clk_half: assert property (
      $changed(uplink_rx_clock_out) |=> $stable(uplink_rx_clock_out)[*3])
      else $error("rx link clock half period too short");
   a_tx_clk_half: assert property (
      $changed(uplink_tx_clock_in) |=> $stable(uplink_tx_clock_in)[*3])
      else $error("tx link clock half period too short");
   a_rx_data_launch: assert property (
      $changed(uplink_rx_data_out) |-> s_rx_edge_soon)
      else $error("rx data moved away from a link clock edge");
   a_rx_ctl_launch: assert property (
      $changed(uplink_rx_valid_out) |-> s_rx_edge_soon)
      else $error("rx control moved away from a link clock edge");
   a_tx_data_launch: assert property (
      $changed(uplink_tx_data_in) |-> s_tx_edge_soon)
      else $error("tx data moved away from a link clock edge");
   a_tx_ctl_launch: assert property (
      $changed(uplink_tx_enable_in) |-> s_tx_edge_soon)
      else $error("tx control moved away from a link clock edge");
   a_rx_err_valid: assert property (
      uplink_rx_error_out |-> uplink_rx_valid_out)
      else $error("rx error without valid");
   a_tx_err_valid: assert property (
      uplink_tx_error_in |-> uplink_tx_enable_in)
      else $error("tx error without enable");
   a_col_needs_crs: assert property (
      uplink_collision |-> uplink_carrier_sense)
      else $error("collision without carrier");
endmodule
`default_nettype wire

// ### uplink_gmii_rgmii_port_tb.sv
/*
 * uplink_gmii_rgmii_port_tb: both ends joined by ugp_link_if, run through
 * gmii/rgmii modes with random bytes both ways. Assumes one 40 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
module uplink_gmii_rgmii_port_tb;
   import ugp_pkg::*;
   logic core_clk_i = 0, rstn_i = 0, role_select_strap_i = 0, speed_select_strap_i = 1;
   logic [1:0] interface_select_strap_i = 0;
   logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, tx_data_i = 0, rx_data_o, h_td = 0;
   logic [7:0] h_rd;
   logic reg_write_i = 0, phy_role_o, tx_valid_i = 0, tx_error_i = 0, tx_ready_o, rx_valid_o;
   logic rx_error_o, collision_o, carrier_o, h_role = 0, h_rgmii = 0, h_gig = 1, h_half = 0;
   logic h_txd = 0, h_rxd = 0, h_tv = 0, h_te = 0, h_tr, h_rv, h_re, h_col, h_crs, col_seen;
   logic crs_seen;
   logic [8:0] d_exp[$], d_got[$], h_exp[$], h_got[$];
   int fail_count = 0, comparisons = 0, cycles = 0, seed = 70;
   ugp_link_if link ();
   ugp_device_end u_ugp_device_end (.core_clk_i, .rstn_i, .link(link), .role_select_strap_i,
      .interface_select_strap_i, .speed_select_strap_i, .reg_addr_i, .reg_write_i, .reg_wdata_i,
      .reg_rdata_o, .phy_role_o, .tx_valid_i, .tx_error_i, .tx_data_i, .tx_ready_o, .rx_valid_o,
      .rx_error_o, .rx_data_o, .rx_frame_o(), .collision_o, .carrier_o);
   ugp_host_end u_ugp_host_end (.core_clk_i, .rstn_i, .link(link), .phy_role_i(h_role),
      .rgmii_i(h_rgmii), .gig_i(h_gig), .half_i(h_half), .tx_delay_i(h_txd), .rx_delay_i(h_rxd),
      .tx_valid_i(h_tv), .tx_error_i(h_te), .tx_data_i(h_td), .tx_ready_o(h_tr),
      .rx_valid_o(h_rv), .rx_error_o(h_re), .rx_data_o(h_rd), .rx_frame_o(), .collision_o(h_col),
      .carrier_o(h_crs));
   ugp_link_checker u_ugp_link_checker (.core_clk_i, .rstn_i,
      .uplink_tx_enable_in(link.uplink_tx_enable_in), .uplink_tx_error_in(link.uplink_tx_error_in),
      .uplink_tx_data_in(link.uplink_tx_data_in), .uplink_tx_clock_in(link.uplink_tx_clock_in),
      .uplink_rx_valid_out(link.uplink_rx_valid_out),
      .uplink_rx_error_out(link.uplink_rx_error_out), .uplink_rx_data_out(link.uplink_rx_data_out),
      .uplink_rx_clock_out(link.uplink_rx_clock_out), .uplink_collision(link.uplink_collision),
      .uplink_carrier_sense(link.uplink_carrier_sense));
   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task automatic summarize();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      {reg_addr_i, reg_wdata_i, reg_write_i} = {a, d, 1'b1};
      @(negedge core_clk_i);
      reg_write_i = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk_i);
      reg_addr_i = a;
      @(negedge core_clk_i);
      check({1'b0, reg_rdata_o}, {1'b0, exp});
   endtask
   // byte 0 and the last byte are the all-zero and all-one corners
   task automatic send(input bit dev, input int n, input bit e);
      logic [8:0] u;
      @(negedge core_clk_i);
      for (int i = 0; i < n; i++) begin
         u = {e && i == 2, (i == 0) ? 8'h00 : (i == n - 1) ? 8'hFF : 8'($random(seed))};
         if (dev) begin
            h_exp.push_back(u);
            {tx_error_i, tx_data_i, tx_valid_i} = {u, 1'b1};
         end else begin
            d_exp.push_back(u);
            {h_te, h_td, h_tv} = {u, 1'b1};
         end
         do @(negedge core_clk_i); while ((dev ? tx_ready_o : h_tr) !== 1'b1);
      end
      if (dev) tx_valid_i = 1'b0;
      else h_tv = 1'b0;
   endtask
   function automatic logic [7:0] cfg_val(input int m);
      cfg_val = (m == 0) ? 8'hC8 : (m == 1) ? 8'h5B : (m == 2) ? 8'h0F : 8'h20;
   endfunction
   // sampled away from the launching edge so every registered output has settled
   always @(negedge core_clk_i) begin
      cycles <= cycles + 1;
      if (carrier_o === 1'b1 || h_crs === 1'b1) crs_seen = 1'b1;
      if (rx_valid_o === 1'b1) d_got.push_back({rx_error_o, rx_data_o});
      if (h_rv === 1'b1) h_got.push_back({h_re, h_rd});
      if (collision_o === 1'b1 || h_col === 1'b1) col_seen = 1'b1;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end
   // modes: 0 gmii gig mac role, 1 rgmii gig, 2 rgmii 10/100, 3 gmii 10/100 half, no egress delay
   initial begin
      for (int m = 0; m < 4; m++) begin
         rstn_i = 1'b0;
         role_select_strap_i = (m != 0);
         interface_select_strap_i = (m == 1 || m == 2) ? IFSEL_RGMII : 2'h0;
         speed_select_strap_i = (m < 2);
         {h_role, h_rgmii, h_gig, h_half} = {m == 0, m == 1 || m == 2, m < 2, m == 3};
         {h_txd, h_rxd} = {m != 1, m == 3};
         repeat (3) @(negedge core_clk_i);
         rstn_i = 1'b1;
         repeat (6) @(negedge core_clk_i);
         check({8'h00, phy_role_o}, {8'h00, m != 0});
         reg_rd(CFG_OFFSET, {1'b0, speed_select_strap_i, 3'b001, 1'b0, interface_select_strap_i});
         reg_wr(CFG_OFFSET, cfg_val(m));
         reg_rd(CFG_OFFSET, cfg_val(m));
         d_exp.delete();
         d_got.delete();
         h_exp.delete();
         h_got.delete();
         {col_seen, crs_seen} = 2'h0;
         fork
            send(1'b1, 6, 1'b1);
            send(1'b0, 6, 1'b1);
         join
         for (int k = 0; k < 3000 && (d_got.size() < 6 || h_got.size() < 6); k++)
            @(negedge core_clk_i);
         for (int i = 0; i < 6; i++) begin
            check(d_got[i], d_exp[i]);
            check(h_got[i], h_exp[i]);
         end
         check({8'h00, col_seen}, {8'h00, m == 3});
         check({8'h00, crs_seen}, {8'h00, m == 0 || m == 3});
      end
      reg_wr(DRV_OFFSET, 8'h5A);
      reg_rd(DRV_OFFSET, 8'h5A);
      reg_rd(8'h00, REG_ZERO);
      summarize();
   end
endmodule
`default_nettype wire
